// ---- hdl/ddrrt_consts.svh ----
/*
 * constants of the ddr3 command timing block: field positions, reset
 * values, encodings and timing figures as macros.
 * assumes it is included by bare name from the package and the modules.
 */
// Functional notes
// - time limits become clock counts by dividing by average period, rounding up.
// - auto precharge waits internally until activate-to-precharge minimum has elapsed.
// - eight-beat or on-the-fly chop: recovery starts four clocks after write latency.
// - chop fixed by mode register: recovery starts two clocks after write latency.
`ifndef DDRRT_CONSTS_SVH
`define DDRRT_CONSTS_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define DDRRT_NUM_BANKS        8
`define DDRRT_BA_W             3
`define DDRRT_ADDR_W           13

// ----------------------------------------------------------------
// mode register field positions
// ----------------------------------------------------------------
`define DDRRT_MR0_SEL          3'h0
`define DDRRT_MR1_SEL          3'h1
`define DDRRT_MR2_SEL          3'h2
`define DDRRT_MR0_BL_LO        0
`define DDRRT_MR0_WR_LO        9
`define DDRRT_MR1_DLL_OFF_BIT  0
`define DDRRT_MR2_CWL_LO       3
`define DDRRT_AP_BIT           10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DDRRT_RST_WRITE_LAT    5'h05
`define DDRRT_RST_WR_RECOV     5'h05

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DDRRT_CLK_PERIOD_NS    25
`define DDRRT_CWL_BASE         5'h05
`define DDRRT_WR_START_LONG    5'h04
`define DDRRT_WR_START_SHORT   5'h02
`define DDRRT_DLLOFF_WR_MIN_CK 5'h04
`define DDRRT_DLLOFF_WR_MIN_NS 15

`endif

// ---- hdl/ddrrt_pkg.sv ----
/*
 * types of the ddr3 command timing block: commands, burst modes,
 * bank states, pin and status carriers, and the decoders.
 * assumes ddrrt_consts.svh is on the include path.
 */
`include "ddrrt_consts.svh"

package ddrrt_pkg;

    // command encoding of {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        CMD_MODE_SET = 3'h0,
        CMD_REF      = 3'h1,
        CMD_PRE      = 3'h2,
        CMD_ACT      = 3'h3,
        CMD_WR       = 3'h4,
        CMD_RD       = 3'h5,
        CMD_ZQ       = 3'h6,
        CMD_NOP      = 3'h7
    } ddrrt_cmd_type;

    typedef enum logic [1:0] {
        BURST_EIGHT_FIXED = 2'h0,
        BURST_ON_THE_FLY  = 2'h1,
        BURST_CHOP_FIXED  = 2'h2,
        BURST_RESERVED    = 2'h3
    } ddrrt_burst_mode_type;

    // gray steps along idle, active, write wait, write recovery, ap pending
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ACTIVE   = 3'h1,
        ST_WR_WAIT  = 3'h3,
        ST_WR_RECOV = 3'h2,
        ST_AP_PEND  = 3'h6
    } ddrrt_bank_state_type;

    typedef struct packed {
        logic                       cs_n;
        logic                       ras_n;
        logic                       cas_n;
        logic                       we_n;
        logic                       cke;
        logic [`DDRRT_BA_W-1:0]     ba;
        logic [`DDRRT_ADDR_W-1:0]   addr;
    } ddrrt_pins_type;

    typedef struct packed {
        logic open;
        logic ras_met;
        logic wr_busy;
        logic ap_pending;
    } ddrrt_bank_stat_type;

    // deselect and clock enable low both read as no operation
    function automatic ddrrt_cmd_type ddrrt_decode(input ddrrt_pins_type p);
        if (p.cs_n || !p.cke)
            return CMD_NOP;
        return ddrrt_cmd_type'({p.ras_n, p.cas_n, p.we_n});
    endfunction

    // write recovery field of mode register 0 to clock count
    function automatic logic [4:0] ddrrt_recov_decode(input logic [2:0] code);
        case (code)
            3'h1:    return 5'h05;
            3'h2:    return 5'h06;
            3'h3:    return 5'h07;
            3'h4:    return 5'h08;
            3'h5:    return 5'h0a;
            3'h6:    return 5'h0c;
            3'h7:    return 5'h0e;
            default: return 5'h10;
        endcase
    endfunction

endpackage

// ---- hdl/ddrrt_bank.sv ----
/*
 * one bank tracker: activate-to-precharge timer, write recovery
 * start and length, internally generated auto precharge.
 * assumes command strobes arrive only together with ck_tick_i.
 */
`timescale 1ns/100ps
`default_nettype none

`include "ddrrt_consts.svh"

module ddrrt_bank #(
    parameter logic [7:0] RAS_LIMIT = 8'h02
) (
    input  wire logic                          clk_i,
    input  wire logic                          srst_i,
    input  wire logic                          ck_tick_i,
    input  wire logic                          act_i,
    input  wire logic                          pre_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    input  wire logic                          auto_pre_i,
    input  wire logic                          chop_fixed_i,
    input  wire logic [4:0]                    write_latency_i,
    input  wire logic [4:0]                    write_recovery_i,
    output logic                               ap_precharge_o,
    output ddrrt_pkg::ddrrt_bank_stat_type     stat_o
);
    import ddrrt_pkg::*;

    ddrrt_bank_state_type state;
    logic [4:0]           cnt;
    logic                 ap_flag;
    logic [7:0]           ras_cnt;
    logic                 ras_met;

    // ----------------------------------------------------------------
    // activate-to-precharge timer
    // ----------------------------------------------------------------
    // counts system clocks, so the limit is the rounded-up time figure
    always_ff @(posedge clk_i) begin
        if (srst_i)
            ras_cnt <= 8'h00;
        else if (act_i && state == ST_IDLE) // activate to an open bank is refused, keep its row time
            ras_cnt <= 8'h01;
        else if (ras_cnt != RAS_LIMIT)
            ras_cnt <= ras_cnt + 8'h01;
    end
    assign ras_met = (ras_cnt == RAS_LIMIT);

    // ----------------------------------------------------------------
    // bank sequence, advanced on link clock rising edges
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state   <= ST_IDLE;
            cnt     <= 5'h00;
            ap_flag <= 1'b0;
        end else if (ck_tick_i) begin
            case (state)
                ST_IDLE: begin
                    if (act_i)
                        state <= ST_ACTIVE;
                end
                ST_ACTIVE: begin
                    if (wr_i) begin
                        state   <= ST_WR_WAIT;
                        cnt     <= write_latency_i + (chop_fixed_i ? `DDRRT_WR_START_SHORT
                                                                   : `DDRRT_WR_START_LONG);
                        ap_flag <= auto_pre_i;
                    end else if (rd_i && auto_pre_i) begin
                        state <= ST_AP_PEND;
                    end else if (pre_i) begin
                        state <= ST_IDLE;
                    end
                end
                ST_WR_WAIT: begin
                    if (cnt == 5'h01) begin
                        state <= ST_WR_RECOV;
                        cnt   <= write_recovery_i;
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                ST_WR_RECOV: begin
                    if (cnt == 5'h01)
                        state <= ap_flag ? ST_AP_PEND : ST_ACTIVE;
                    else
                        cnt <= cnt - 5'h01;
                end
                ST_AP_PEND: begin
                    // precharge is held off until the row has been open long enough
                    if (ras_met)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ap_precharge_o <= 1'b0;
            stat_o         <= '0;
        end else begin
            ap_precharge_o    <= ck_tick_i && state == ST_AP_PEND && ras_met;
            stat_o.open       <= state != ST_IDLE;
            stat_o.ras_met    <= ras_met;
            stat_o.wr_busy    <= state == ST_WR_WAIT || state == ST_WR_RECOV;
            stat_o.ap_pending <= state == ST_AP_PEND;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [5:0] wr_ticks;
    logic [4:0] start_lat;
    logic [4:0] rec_ticks;
    logic [4:0] recov_lat;

    // helper counters of link edges since the write and within recovery
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ticks  <= 6'h00;
            start_lat <= 5'h00;
            rec_ticks <= 5'h00;
            recov_lat <= 5'h00;
        end else if (ck_tick_i) begin
            if (state == ST_ACTIVE && wr_i) begin
                wr_ticks  <= 6'h01;
                start_lat <= write_latency_i + (chop_fixed_i ? 5'h02 : 5'h04);
            end else if (wr_ticks != 6'h3f) begin
                wr_ticks <= wr_ticks + 6'h01;
            end
            if (state == ST_WR_WAIT && cnt == 5'h01) begin
                rec_ticks <= 5'h01;
                recov_lat <= write_recovery_i;
            end else begin
                rec_ticks <= rec_ticks + 5'h01;
            end
        end
    end

    ap_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(ap_precharge_o) |-> ras_cnt == RAS_LIMIT && !$past(act_i))
        else $error("auto precharge before activate-to-precharge minimum");

    ap_release_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ck_tick_i && state == ST_AP_PEND && ras_met) |=> ap_precharge_o ##1 !ap_precharge_o)
        else $error("auto precharge not issued once the row time was met");

    wr_start_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state == ST_WR_RECOV && $past(state) == ST_WR_WAIT) |-> {1'b0, start_lat} == wr_ticks - 6'h01)
        else $error("write recovery started at the wrong edge");

    rec_length_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state != ST_WR_RECOV && $past(state) == ST_WR_RECOV) |-> rec_ticks - 5'h01 == recov_lat)
        else $error("write recovery length differs from programmed count");

    wr_path_c: cover property (@(posedge clk_i) disable iff (srst_i)
        state == ST_WR_RECOV ##1 state == ST_AP_PEND);
    rd_ap_c: cover property (@(posedge clk_i) disable iff (srst_i)
        state == ST_AP_PEND && !ras_met ##[1:20] ap_precharge_o);

endmodule

`default_nettype wire

// ---- hdl/ddrrt_top.sv ----
/*
 * ddr3 command timing inside the memory device: samples the command
 * clock and command pins, keeps the mode registers that steer write
 * latency, burst chop, write recovery and the locked-loop-off mode,
 * and runs one bank tracker per bank.
 * assumes the command clock is far slower than clk_i (at most a third)
 * and that command pins are steady for three clk_i cycles around each
 * rising command clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

`include "ddrrt_consts.svh"

module ddrrt_top #(
    parameter int RAS_MIN_NS = 35
) (
    input  wire logic                                             clk_i,
    input  wire logic                                             srst_i,
    input  wire logic                                             ck_i,
    input  wire ddrrt_pkg::ddrrt_pins_type                        pins_i,
    output ddrrt_pkg::ddrrt_bank_stat_type [`DDRRT_NUM_BANKS-1:0] bank_stat_o,
    output logic [`DDRRT_NUM_BANKS-1:0]                           ap_precharge_o,
    output logic [4:0]                                            write_latency_o,
    output logic [4:0]                                            write_recovery_o,
    output ddrrt_pkg::ddrrt_burst_mode_type                       burst_mode_o,
    output logic                                                  dll_off_o,
    output logic                                                  read_dll_off_o
);
    import ddrrt_pkg::*;

    // ----------------------------------------------------------------
    // time to clock conversion
    // ----------------------------------------------------------------
    // a least time rounds up, and never below one cycle
    localparam int RAS_CEIL = (RAS_MIN_NS + `DDRRT_CLK_PERIOD_NS - 1) / `DDRRT_CLK_PERIOD_NS;
    localparam int RAS_MIN_CLK = (RAS_CEIL < 1) ? 1 : RAS_CEIL;
    localparam logic [7:0] RAS_LIMIT = RAS_MIN_CLK[7:0];
    // 15ns is under one command clock whenever clk_i can sample that clock,
    // so the four-cycle floor is the one that ever binds in this mode
    localparam int DLLOFF_WR_NS = `DDRRT_DLLOFF_WR_MIN_NS;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic           ck_meta;
    logic           ck_sync;
    logic           ck_prev;
    ddrrt_pins_type pins_meta;
    ddrrt_pins_type pins_sync;

    // two flops on every pin, only the second read by logic; ck_i has a third flop for edge detection
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ck_meta   <= 1'b0;
            ck_sync   <= 1'b0;
            ck_prev   <= 1'b0;
            pins_meta <= '1;
            pins_sync <= '1;
        end else begin
            ck_meta   <= ck_i;
            ck_sync   <= ck_meta;
            ck_prev   <= ck_sync;
            pins_meta <= pins_i;
            pins_sync <= pins_meta;
        end
    end

    // ----------------------------------------------------------------
    // command capture on the rising command clock edge
    // ----------------------------------------------------------------
    logic           ck_tick;
    ddrrt_pins_type pins_cap;
    ddrrt_cmd_type  cmd;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ck_tick  <= 1'b0;
            pins_cap <= '1;
        end else begin
            ck_tick <= ck_sync && !ck_prev;
            if (ck_sync && !ck_prev)
                pins_cap <= pins_sync;
        end
    end

    assign cmd = ddrrt_decode(pins_cap);

    // ----------------------------------------------------------------
    // mode registers
    // ----------------------------------------------------------------
    logic       mode_set_hit;
    logic [4:0] recov_prog;
    logic [4:0] next_recov_eff;

    assign mode_set_hit = ck_tick && cmd == CMD_MODE_SET;

    // write latency and write recovery are kept as clock counts
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            write_latency_o <= `DDRRT_RST_WRITE_LAT;
            recov_prog      <= `DDRRT_RST_WR_RECOV;
            burst_mode_o    <= BURST_EIGHT_FIXED;
            dll_off_o       <= 1'b0;
        end else if (mode_set_hit) begin
            case (pins_cap.ba)
                `DDRRT_MR0_SEL: begin
                    burst_mode_o <= ddrrt_burst_mode_type'(pins_cap.addr[`DDRRT_MR0_BL_LO +: 2]);
                    recov_prog   <= ddrrt_recov_decode(pins_cap.addr[`DDRRT_MR0_WR_LO +: 3]);
                end
                `DDRRT_MR1_SEL: begin
                    dll_off_o <= pins_cap.addr[`DDRRT_MR1_DLL_OFF_BIT];
                end
                `DDRRT_MR2_SEL: begin
                    write_latency_o <= `DDRRT_CWL_BASE + {2'b00, pins_cap.addr[`DDRRT_MR2_CWL_LO +: 3]};
                end
                default: begin
                end
            endcase
        end
    end

    // recovery in locked-loop-off mode is never shorter than four clocks
    always_comb begin
        next_recov_eff = recov_prog;
        if (dll_off_o && recov_prog < `DDRRT_DLLOFF_WR_MIN_CK)
            next_recov_eff = `DDRRT_DLLOFF_WR_MIN_CK;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i)
            write_recovery_o <= `DDRRT_RST_WR_RECOV;
        else
            write_recovery_o <= next_recov_eff;
    end

    // ----------------------------------------------------------------
    // reads with the locked loop off
    // ----------------------------------------------------------------
    // the device cannot time a read without the loop; flag it for the system
    always_ff @(posedge clk_i) begin
        if (srst_i)
            read_dll_off_o <= 1'b0;
        else
            read_dll_off_o <= ck_tick && cmd == CMD_RD && dll_off_o;
    end

    // ----------------------------------------------------------------
    // bank trackers
    // ----------------------------------------------------------------
    localparam int BA_W = `DDRRT_BA_W;

    logic chop_fixed;
    assign chop_fixed = burst_mode_o == BURST_CHOP_FIXED;

    for (genvar g = 0; g < `DDRRT_NUM_BANKS; g++) begin : g_bank
        logic sel;
        assign sel = pins_cap.ba == BA_W'(g);

        ddrrt_bank #(
            .RAS_LIMIT        (RAS_LIMIT)
        ) u_bank (
            .clk_i            (clk_i),
            .srst_i           (srst_i),
            .ck_tick_i        (ck_tick),
            .act_i            (ck_tick && cmd == CMD_ACT && sel),
            .pre_i            (ck_tick && cmd == CMD_PRE && (sel || pins_cap.addr[`DDRRT_AP_BIT])),
            .wr_i             (ck_tick && cmd == CMD_WR && sel),
            .rd_i             (ck_tick && cmd == CMD_RD && sel),
            .auto_pre_i       (pins_cap.addr[`DDRRT_AP_BIT]),
            .chop_fixed_i     (chop_fixed),
            .write_latency_i  (write_latency_o),
            .write_recovery_i (write_recovery_o),
            .ap_precharge_o   (ap_precharge_o[g]),
            .stat_o           (bank_stat_o[g])
        );
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    tick_spacing_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ck_tick |=> !ck_tick)
        else $error("two command clock edges in adjacent cycles");

    ras_round_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ck_tick |-> RAS_MIN_CLK * `DDRRT_CLK_PERIOD_NS >= RAS_MIN_NS
                 && (RAS_MIN_CLK - 1) * `DDRRT_CLK_PERIOD_NS < RAS_MIN_NS + `DDRRT_CLK_PERIOD_NS)
        else $error("row time count not rounded up");

    dlloff_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        dll_off_o ##1 dll_off_o |-> write_recovery_o >= `DDRRT_DLLOFF_WR_MIN_CK
                               && write_recovery_o * `DDRRT_CLK_PERIOD_NS >= DLLOFF_WR_NS)
        else $error("write recovery below the locked-loop-off floor");

    mr2_wl_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (mode_set_hit && pins_cap.ba == `DDRRT_MR2_SEL) |=>
            write_latency_o == `DDRRT_CWL_BASE + {2'b00, $past(pins_cap.addr[5:3])})
        else $error("write latency not taken from mode register 2");

    rd_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
        read_dll_off_o |-> $past(dll_off_o) && $past(cmd) == CMD_RD)
        else $error("read flag without a read in locked-loop-off mode");

    chop_mode_c: cover property (@(posedge clk_i) disable iff (srst_i)
        chop_fixed && ck_tick && cmd == CMD_WR);
    dll_read_c: cover property (@(posedge clk_i) disable iff (srst_i)
        read_dll_off_o);

endmodule

`default_nettype wire

// ---- dv/ddrrt_ctrl_model.sv ----
/*
 * controller model: free running command clock, one command per clock.
 * assumes go_i is held high until ack_o is seen high.
 */
`timescale 1ns/100ps
`default_nettype none

module ddrrt_ctrl_model (
    input  wire logic                      go_i,
    input  wire ddrrt_pkg::ddrrt_pins_type cmd_i,
    output logic                           ck_o,
    output ddrrt_pkg::ddrrt_pins_type      pins_o,
    output logic                           ack_o
);
    import ddrrt_pkg::*;

    // 200 ns command clock, phase unrelated to the system clock
    initial begin
        ck_o = 1'b0;
        #37;
        forever #100 ck_o = ~ck_o;
    end

    // pins change on the falling edge so they stand still around each rise
    // no refresh, self refresh or power-down is ever requested: a run is far
    // shorter than one refresh window and the case is never hot
    initial pins_o = '1;
    initial ack_o = 1'b0;
    always @(negedge ck_o) begin
        pins_o <= go_i ? cmd_i : '1;
        ack_o  <= go_i;
    end
endmodule

`default_nettype wire

// ---- dv/ddrrt_top_tb.sv ----
/*
 * self-checking bench of the command timing block.
 * assumes the controller model drives the command clock and pins.
 */
`timescale 1ns/100ps
`default_nettype none

module ddrrt_top_tb;
    import ddrrt_pkg::*;

    logic                      clk_i;
    logic                      srst_i;
    logic                      go;
    logic                      ck;
    logic                      ack;
    ddrrt_pins_type            cmd;
    ddrrt_pins_type            pins;
    ddrrt_bank_stat_type [7:0] stat;
    logic [7:0]                ap;
    logic [4:0]                lat;
    logic [4:0]                wr;
    ddrrt_burst_mode_type      bm;
    logic                      dll_off;
    logic                      rd_off;
    int                        miscompares = 0;
    int                        checked = 0;

    // 1000 ns activate-to-precharge is exactly 40 system clocks, five command clocks
    ddrrt_top #(.RAS_MIN_NS(1000)) DUT (.clk_i(clk_i), .srst_i(srst_i), .ck_i(ck), .pins_i(pins),
        .bank_stat_o(stat), .ap_precharge_o(ap), .write_latency_o(lat), .write_recovery_o(wr),
        .burst_mode_o(bm), .dll_off_o(dll_off), .read_dll_off_o(rd_off));

    ddrrt_ctrl_model PARTNER (.go_i(go), .cmd_i(cmd), .ck_o(ck), .pins_o(pins), .ack_o(ack));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one command handed to the model; returns once it stands on the pins
    task automatic send(input ddrrt_cmd_type op, input logic [2:0] ba, input logic [12:0] addr);
        int n;
        n = 0;
        while (ack === 1'b1 && n < 100) begin @(posedge clk_i); n++; end
        go  <= 1'b1;
        cmd <= '{cs_n: 1'b0, ras_n: op[2], cas_n: op[1], we_n: op[0], cke: 1'b1, ba: ba, addr: addr};
        while (ack !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
        go <= 1'b0;
        if (n >= 100) begin miscompares++; stop_test(); end
    endtask

    // command clock rises after the command edge until an auto precharge pulse
    task automatic count_to_ap(output int rises);
        logic prev;
        int   n;
        prev  = ck;
        rises = -1;
        n     = 0;
        while (ap === 8'h00 && n < 400) begin
            @(posedge clk_i);
            n++;
            if (ck && !prev) rises++;
            prev = ck;
        end
        if (n >= 400) begin miscompares++; stop_test(); end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        cmp("write latency", 8'h05, 8'(lat));
        cmp("write recovery", 8'h05, 8'(wr));
        cmp("burst mode", 8'h00, 8'(bm));
        cmp("ap pulse", 8'h00, ap);
        cmp("bank status", 8'h00, 8'(|stat));
        $display("test reset done");
    endtask

    // recovery start moves with burst mode and write latency, recovery code 3 is 7 clocks
    task automatic t_write;
        int r;
        for (int m = 0; m < 3; m++) begin
            send(CMD_MODE_SET, 3'h2, 13'(m << 3));
            send(CMD_MODE_SET, 3'h0, 13'h0600 | 13'(m));
            send(CMD_ACT, 3'h1, 13'h0000);
            cmp("write latency", 8'(5 + m), 8'(lat));
            cmp("burst mode", 8'(m), 8'(bm));
            cmp("write recovery", 8'h07, 8'(wr));
            send(CMD_WR, 3'h1, 13'h0400);
            count_to_ap(r);
            cmp("recovery rises", 8'(5 + m + (m == 2 ? 2 : 4) + 7 + 1), 8'(r));
            repeat (8) @(posedge clk_i);
        end
        $display("test write recovery done");
    endtask

    // read with auto precharge two clocks after activate: precharge waits
    // until five clocks after the activate, three after the read
    task automatic t_ras;
        int r;
        send(CMD_ACT, 3'h2, 13'h0000);
        send(CMD_RD, 3'h2, 13'h0400);
        cmp("bank open", 8'h08, 8'(stat[2]));
        count_to_ap(r);
        cmp("ras hold", 8'h03, 8'(r));
        repeat (2) @(posedge clk_i);
        cmp("bank closed", 8'h04, 8'(stat[2]));
        $display("test activate hold done");
    endtask

    // locked loop off: recovery stays at the programmed 7 clocks and read flagged
    task automatic t_dll;
        int   n;
        logic seen;
        seen = 1'b0;
        send(CMD_MODE_SET, 3'h1, 13'h0001);
        send(CMD_ACT, 3'h3, 13'h0000);
        send(CMD_RD, 3'h3, 13'h0000);
        for (n = 0; n < 16; n++) begin @(posedge clk_i); seen |= (rd_off === 1'b1); end
        cmp("dll off", 8'h01, 8'(dll_off));
        cmp("dll off recovery", 8'h07, 8'(wr));
        cmp("read dll off", 8'h01, 8'(seen));
        $display("test dll off done");
    endtask

    // ----------------------------------------------------------------
    // clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        srst_i = 1'b1;
        go     = 1'b0;
        cmd    = '1;
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_write();
        t_ras();
        t_dll();
        stop_test();
    end
endmodule

`default_nettype wire
